// File: core/hlt_map.svh
`ifndef HLT_MAP_SVH
`define HLT_MAP_SVH

// mode field layout
`define HLT_MODE_W      5
`define HLT_FAM_HI      4
`define HLT_FAM_LO      3
`define HLT_VAR_HI      2
`define HLT_VAR_LO      0

// mode family codes
`define HLT_FAM_FREE    2'h0
`define HLT_FAM_ONESHOT 2'h1
`define HLT_FAM_MONO    2'h2
`define HLT_FAM_RSVD    2'h3

// variant codes within a family
`define HLT_VAR_0       3'h0
`define HLT_VAR_1       3'h1
`define HLT_VAR_2       3'h2
`define HLT_VAR_3       3'h3
`define HLT_VAR_4       3'h4
`define HLT_VAR_5       3'h5
`define HLT_VAR_6       3'h6
`define HLT_VAR_7       3'h7

// reset values
`define HLT_CNT_ZERO    8'h00
`define HLT_MODE_RST    5'h00

// enable delay depth and external signal synchroniser depth
`define HLT_ON_SYNC     2
`define HLT_ERS_SYNC    2

`endif

// File: core/hlt_pkg.sv
package hlt_pkg;

    // external signal after synchronisation and debug qualification
    typedef struct packed {
        logic rise;
        logic fall;
        logic level;
    } hlt_ers_t;

    // start state for the edge started modes
    typedef enum logic [2:0] {
        HLT_ST_IDLE  = 3'h1,
        HLT_ST_ARMED = 3'h2,
        HLT_ST_RUN   = 3'h4
    } hlt_state_t;

endpackage : hlt_pkg

// File: core/hlt_sync.sv
`timescale 1ns/1ps
`default_nettype none

module hlt_sync #(
    parameter int STAGES = 2
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic async_in,
    output logic      sync_out
);

    logic [STAGES-1:0] sync_chain_ff;

    ////////////////////////////////////////////////////////////////////////
    // plain flop chain, only the last stage is read
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_chain_ff <= '0;
        end else begin
            sync_chain_ff <= {sync_chain_ff[STAGES-2:0], async_in};
        end
    end

    assign sync_out = sync_chain_ff[STAGES-1];

endmodule : hlt_sync

`default_nettype wire

// File: core/hlt_ers_edge.sv
`timescale 1ns/1ps
`default_nettype none

module hlt_ers_edge (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         ers_sync,
    input  wire logic         debug_mode,
    output hlt_pkg::hlt_ers_t ers_evt
);

    logic last_ff;

    ////////////////////////////////////////////////////////////////////////
    // history of the synchronised level
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            last_ff <= 1'b0;
        end else begin
            last_ff <= ers_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // qualified events; level frozen in debug so gates do not flip
    // debug blocks triggers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ers_evt <= '0;
        end else if (debug_mode) begin
            ers_evt.rise <= 1'b0;
            ers_evt.fall <= 1'b0;
        end else begin
            ers_evt.rise  <= ers_sync & ~last_ff;
            ers_evt.fall  <= ~ers_sync & last_ff;
            ers_evt.level <= ers_sync;
        end
    end

endmodule : hlt_ers_edge

`default_nettype wire

// File: core/hlt_mode_ctrl.sv
// Functional notes
// - five-bit mode: family and start variant
// - family 11 and three mono codes reserved
// - debug mode ignores external trigger events
// - re-enable needs fresh edge to resume
// - one-shot match clears enable, stops zero
// - monostable match stops zero, keeps enable
// - hardware gate counts at active level
// - level reset holds count at level
// - level-start one-shot, opposite level resets
// - enable and signal synchronised two clocks
// - instruction clock: enable next period
// - period match pulses, count clears next
`timescale 1ns/1ps
`default_nettype none
`include "hlt_map.svh"

module hlt_mode_ctrl #(
    parameter int CNT_W = 8
) (
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire logic [`HLT_MODE_W-1:0]   hardware_limit_control,
    input  wire logic [CNT_W-1:0]         period_value,
    input  wire logic                     on_write,
    input  wire logic                     on_wdata,
    input  wire logic                     instr_clk_sel,
    input  wire logic                     debug_mode,
    input  wire logic                     external_reset_signal,
    output logic [CNT_W-1:0]              count_value,
    output logic                          timer_on,
    output logic                          period_match,
    output logic                          counting,
    output logic                          mode_reserved
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // reserved selections
    function automatic logic is_reserved(input logic [`HLT_MODE_W-1:0] m);
        logic [1:0] fam;
        logic [2:0] var_c;
        fam   = m[`HLT_FAM_HI:`HLT_FAM_LO];
        var_c = m[`HLT_VAR_HI:`HLT_VAR_LO];
        is_reserved = (fam == `HLT_FAM_RSVD) ||
                      ((fam == `HLT_FAM_MONO) &&
                       ((var_c == `HLT_VAR_0) || (var_c == `HLT_VAR_4) ||
                        (var_c == `HLT_VAR_5)));
    endfunction : is_reserved

    // start edge chosen by the variant: rising, falling or either
    function automatic logic start_edge(input logic [2:0] var_c,
                                        input hlt_pkg::hlt_ers_t e);
        start_edge = 1'b0;
        case (var_c)
            `HLT_VAR_1, `HLT_VAR_4, `HLT_VAR_6: start_edge = e.rise;
            `HLT_VAR_2, `HLT_VAR_5, `HLT_VAR_7: start_edge = e.fall;
            `HLT_VAR_3:                         start_edge = e.rise | e.fall;
            default:                            start_edge = 1'b0;
        endcase
    endfunction : start_edge

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [1:0]               fam;
    logic [2:0]               var_c;
    logic                     rsvd;
    logic                     ers_sync;
    hlt_pkg::hlt_ers_t        ers;
    logic                     on_ff;
    logic [`HLT_ON_SYNC-1:0]  on_pipe_ff;
    logic                     on_eff;
    logic                     en;
    logic                     needs_edge;
    logic                     is_oneshot;
    logic                     cnt_en;
    logic                     rst_now;
    logic                     match_now;
    logic                     start_now;
    logic [CNT_W-1:0]         count_ff;
    logic                     match_ff;
    logic                     counting_ff;
    logic                     rsvd_ff;
    hlt_pkg::hlt_state_t      state_ff;
    hlt_pkg::hlt_state_t      nxt_state;

    ////////////////////////////////////////////////////////////////////////
    // mode field split
    // family and variant
    assign fam   = hardware_limit_control[`HLT_FAM_HI:`HLT_FAM_LO];
    assign var_c = hardware_limit_control[`HLT_VAR_HI:`HLT_VAR_LO];
    assign rsvd  = is_reserved(hardware_limit_control);

    ////////////////////////////////////////////////////////////////////////
    // external signal path; source timing (spacing, hold) is the
    // sender's job, a shorter pulse may be missed by the two flops
    // edges need spacing
    hlt_sync #(
        .STAGES   (`HLT_ERS_SYNC)
    ) u_ers_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (external_reset_signal),
        .sync_out (ers_sync)
    );

    hlt_ers_edge u_ers_edge (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .ers_sync   (ers_sync),
        .debug_mode (debug_mode),
        .ers_evt    (ers)
    );

    ////////////////////////////////////////////////////////////////////////
    // enable bit; software write and one-shot hardware clear
    // software wins a same-cycle collision so a restart is never lost
    // one-shot clears enable
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            on_ff <= 1'b0;
        end else if (on_write) begin
            on_ff <= on_wdata;
        end else if (match_now && is_oneshot) begin
            on_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enable delay line; set takes effect late, clear acts at once
    // so a cleared one-shot cannot restart from the stale pipe
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            on_pipe_ff <= '0;
        end else begin
            on_pipe_ff <= {on_pipe_ff[`HLT_ON_SYNC-2:0], on_ff};
        end
    end

    assign on_eff = instr_clk_sel ? on_pipe_ff[0] : on_pipe_ff[`HLT_ON_SYNC-1];
    assign en     = on_ff & on_eff & ~rsvd;

    ////////////////////////////////////////////////////////////////////////
    // mode classification
    always_comb begin
        needs_edge = 1'b0;
        is_oneshot = 1'b0;
        case (fam)
            `HLT_FAM_ONESHOT: begin
                needs_edge = (var_c != `HLT_VAR_0);
                is_oneshot = 1'b1;
            end
            `HLT_FAM_MONO: begin
                needs_edge = (var_c == `HLT_VAR_1) || (var_c == `HLT_VAR_2) ||
                             (var_c == `HLT_VAR_3);
                is_oneshot = (var_c == `HLT_VAR_6) || (var_c == `HLT_VAR_7);
            end
            default: begin
                needs_edge = 1'b0;
                is_oneshot = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // count enable per mode
    always_comb begin
        cnt_en = 1'b0;
        case (fam)
            `HLT_FAM_FREE: begin
                case (var_c)
                    `HLT_VAR_1: cnt_en = en & ers.level;
                    `HLT_VAR_2: cnt_en = en & ~ers.level;
                    `HLT_VAR_6: cnt_en = en & ers.level;
                    `HLT_VAR_7: cnt_en = en & ~ers.level;
                    default:    cnt_en = en;
                endcase
            end
            `HLT_FAM_ONESHOT: begin
                cnt_en = (var_c == `HLT_VAR_0) ? en
                                               : en & (state_ff == hlt_pkg::HLT_ST_RUN);
            end
            `HLT_FAM_MONO: begin
                case (var_c)
                    `HLT_VAR_6: cnt_en = en & ers.level;
                    `HLT_VAR_7: cnt_en = en & ~ers.level;
                    default:    cnt_en = en & needs_edge &
                                         (state_ff == hlt_pkg::HLT_ST_RUN);
                endcase
            end
            default: cnt_en = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // count reset per mode; external signal ignored while disabled
    always_comb begin
        rst_now = 1'b0;
        case (fam)
            `HLT_FAM_FREE: begin
                case (var_c)
                    `HLT_VAR_3: rst_now = en & (ers.rise | ers.fall);
                    `HLT_VAR_4: rst_now = en & ers.rise;
                    `HLT_VAR_5: rst_now = en & ers.fall;
                    `HLT_VAR_6: rst_now = en & ~ers.level;
                    `HLT_VAR_7: rst_now = en & ers.level;
                    default:    rst_now = 1'b0;
                endcase
            end
            `HLT_FAM_ONESHOT: begin
                case (var_c)
                    `HLT_VAR_4: rst_now = cnt_en & ers.rise;
                    `HLT_VAR_5: rst_now = cnt_en & ers.fall;
                    `HLT_VAR_6: rst_now = cnt_en & ~ers.level;
                    `HLT_VAR_7: rst_now = cnt_en & ers.level;
                    default:    rst_now = 1'b0;
                endcase
            end
            `HLT_FAM_MONO: begin
                case (var_c)
                    `HLT_VAR_6: rst_now = en & ~ers.level;
                    `HLT_VAR_7: rst_now = en & ers.level;
                    default:    rst_now = 1'b0;
                endcase
            end
            default: rst_now = 1'b0;
        endcase
    end

    assign match_now = cnt_en & ~rst_now & (count_ff == period_value);
    assign start_now = start_edge(var_c, ers);

    ////////////////////////////////////////////////////////////////////////
    // start state machine for edge started modes
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            hlt_pkg::HLT_ST_IDLE: begin
                if (en && needs_edge) begin
                    nxt_state = hlt_pkg::HLT_ST_ARMED;
                end
            end
            hlt_pkg::HLT_ST_ARMED: begin
                if (!en || !needs_edge) begin
                    nxt_state = hlt_pkg::HLT_ST_IDLE;
                end else if (start_now) begin
                    nxt_state = hlt_pkg::HLT_ST_RUN;
                end
            end
            hlt_pkg::HLT_ST_RUN: begin
                if (!en || !needs_edge) begin
                    nxt_state = hlt_pkg::HLT_ST_IDLE;
                end else if (match_now) begin
                    nxt_state = is_oneshot ? hlt_pkg::HLT_ST_IDLE
                                           : hlt_pkg::HLT_ST_ARMED;
                end
            end
            default: nxt_state = hlt_pkg::HLT_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= hlt_pkg::HLT_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counter; reset has priority over counting
    // clear after match
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_ff <= `HLT_CNT_ZERO;
        end else if (rst_now || match_now) begin
            count_ff <= `HLT_CNT_ZERO;
        end else if (cnt_en) begin
            count_ff <= count_ff + CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered status outputs
    // match pulse
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            match_ff    <= 1'b0;
            counting_ff <= 1'b0;
            rsvd_ff     <= 1'b0;
        end else begin
            match_ff    <= match_now;
            counting_ff <= cnt_en & ~rst_now & ~match_now;
            rsvd_ff     <= rsvd;
        end
    end

    assign count_value   = count_ff;
    assign timer_on      = on_ff;
    assign period_match  = match_ff;
    assign counting      = counting_ff;
    assign mode_reserved = rsvd_ff;

endmodule : hlt_mode_ctrl

`default_nettype wire

// File: testbench/hlt_mode_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "hlt_map.svh"

module hlt_mode_ctrl_monitor #(
    parameter int CNT_W = 8
) (
    input wire logic                   clk,
    input wire logic                   sys_rst,
    input wire logic [`HLT_MODE_W-1:0] hardware_limit_control,
    input wire logic [CNT_W-1:0]       period_value,
    input wire logic                   on_write,
    input wire logic                   on_wdata,
    input wire logic                   instr_clk_sel,
    input wire logic                   debug_mode,
    input wire logic                   external_reset_signal,
    input wire logic [CNT_W-1:0]       count_value,
    input wire logic                   timer_on,
    input wire logic                   period_match,
    input wire logic                   counting,
    input wire logic                   mode_reserved
);
    wire logic [4:0] md = hardware_limit_control;
    wire logic       rsv;
    wire logic       edge_free;

    // decode helpers; family 10 also reserves 000, 100, 101
    assign rsv = md[4:3] == 2'h3 || (md[4:3] == 2'h2 && md[2:0] inside {3'h0, 3'h4, 3'h5});
    assign edge_free = md inside {5'h03, 5'h04, 5'h05};

    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////
    // 7-cycle margins cover the two-flop sync plus edge stage; debug must
    // have stood two cycles so events already in the edge stage are drained
    sequence s_dbg;
        (edge_free && debug_mode && counting)[*2];
    endsequence
    sequence s_gate_low;
        (md == 5'h01 && !external_reset_signal)[*7];
    endsequence
    sequence s_lvl_hi;
        (md == 5'h07 && timer_on && external_reset_signal)[*7];
    endsequence

    AST_MATCH: assert property (period_match |->
        $past(count_value) == $past(period_value) && count_value == '0)
        else $error("period match without equal count");
    AST_RSVD: assert property (!$past(sys_rst) |-> mode_reserved == $past(rsv))
        else $error("reserved flag wrong");
    AST_OS_CLR: assert property (md[4:3] == 2'h1 && period_match && !$past(on_write)
        |-> !timer_on ##1 count_value == '0 ##1 count_value == '0)
        else $error("one-shot did not stop");
    AST_MONO: assert property (md inside {5'h11, 5'h12, 5'h13} && period_match
        && !$past(on_write) |-> timer_on ##1 count_value == '0)
        else $error("monostable stop wrong");
    AST_DEBUG: assert property (s_dbg |=>
        count_value != '0 || period_match)
        else $error("reset taken in debug");
    AST_GATE: assert property (s_gate_low |-> $stable(count_value))
        else $error("gate closed but counting");
    AST_LVL: assert property (s_lvl_hi |-> count_value == '0)
        else $error("level reset not held");
    AST_ON_SYNC: assert property ($rose(timer_on) && !instr_clk_sel
        |=> ($stable(count_value))[*2])
        else $error("enable took effect too early");
endmodule : hlt_mode_ctrl_monitor

bind hlt_mode_ctrl hlt_mode_ctrl_monitor #(.CNT_W(CNT_W)) i_mon (
    .clk(clk), .sys_rst(sys_rst), .hardware_limit_control(hardware_limit_control),
    .period_value(period_value), .on_write(on_write), .on_wdata(on_wdata),
    .instr_clk_sel(instr_clk_sel), .debug_mode(debug_mode),
    .external_reset_signal(external_reset_signal), .count_value(count_value),
    .timer_on(timer_on), .period_match(period_match), .counting(counting),
    .mode_reserved(mode_reserved)
);

`default_nettype wire

// File: testbench/hlt_trig_src.sv
`timescale 1ns/1ps
`default_nettype none

module hlt_trig_src (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic trig_req,
    output logic      ers_ff
);
    logic [2:0] gap_ff;

    // follows the request late rather than squeezing edges together
    // edge spacing
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gap_ff <= 3'h0;
            ers_ff <= 1'b0;
        end else if (trig_req != ers_ff && gap_ff >= 3'h5) begin
            gap_ff <= 3'h0;
            ers_ff <= trig_req;
        end else if (gap_ff != 3'h7) begin
            gap_ff <= gap_ff + 3'h1;
        end
    end
endmodule : hlt_trig_src

`default_nettype wire

// File: testbench/test_hardware_limit_timer_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (b)); end end

module test_hardware_limit_timer_mode_control;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic [4:0] md = 5'h00;
    logic [7:0] per = 8'h05;
    logic       on_write = 1'b0;
    logic       on_wdata = 1'b0;
    logic       isel = 1'b0;
    logic       dbg = 1'b0;
    logic       trig_req = 1'b0;
    wire logic  ers;
    wire logic [7:0] cnt;
    wire logic  ton;
    wire logic  pm;
    wire logic  cnt_on;
    wire logic  rsvd;
    int         err_total = 0;
    int         n_checks = 0;
    int         lat [2];

    // 40 MHz timer clock
    always #12.5 clk = ~clk;

    hlt_mode_ctrl #(.CNT_W(8)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .hardware_limit_control(md), .period_value(per),
        .on_write(on_write), .on_wdata(on_wdata), .instr_clk_sel(isel), .debug_mode(dbg),
        .external_reset_signal(ers), .count_value(cnt), .timer_on(ton), .period_match(pm),
        .counting(cnt_on), .mode_reserved(rsvd)
    );
    hlt_trig_src i_src (.clk(clk), .sys_rst(sys_rst), .trig_req(trig_req), .ers_ff(ers));

    ////////////////////////////////////////////////////////////
    // inputs always move 2 ns after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : cyc

    task automatic wr(input logic v);
        on_write = 1'b1;
        on_wdata = v;
        cyc(1);
        on_write = 1'b0;
    endtask : wr

    // short reset per scenario so each starts from count zero
    task automatic setup(input logic [4:0] m, input logic [7:0] p);
        sys_rst = 1'b1;
        trig_req = 1'b0;
        md = m;
        per = p;
        cyc(2);
        sys_rst = 1'b0;
        cyc(1);
    endtask : setup

    task automatic wait_cnt(input logic [7:0] v);
        for (int i = 0; i < 300 && cnt !== v; i++) cyc(1);
        if (cnt !== v) begin
            err_total++;
            $display("[ERR] t=%0t count wait timed out", $time);
            end_sim();
        end
    endtask : wait_cnt

    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////
    task automatic t_swgate;
        setup(5'h00, 8'h05);
        wr(1'b1);
        wait_cnt(8'h05);
        cyc(1);
        `CHK({pm, cnt_on, cnt}, 10'h200)
        cyc(1);
        `CHK({pm, cnt_on, cnt}, 10'h101)
    endtask : t_swgate

    // instruction clock takes the enable one cycle sooner
    task automatic t_lat;
        for (int s = 0; s < 2; s++) begin
            isel = s[0];
            setup(5'h00, 8'hF0);
            wr(1'b1);
            lat[s] = 1;
            while (cnt === 8'h00 && lat[s] < 20) begin
                cyc(1);
                lat[s]++;
            end
            if (cnt === 8'h00) begin
                err_total++;
                $display("[ERR] t=%0t enable latency timed out", $time);
                end_sim();
            end
        end
        isel = 1'b0;
        `CHK(lat[0] - lat[1], 1)
        `CHK(lat[0] >= 3, 1'b1)
    endtask : t_lat

    task automatic t_rsvd;
        logic [4:0] tbl [6] = '{5'h18, 5'h1B, 5'h1F, 5'h10, 5'h14, 5'h15};
        foreach (tbl[i]) begin
            setup(tbl[i], 8'h05);
            wr(1'b1);
            cyc(8);
            `CHK({rsvd, cnt}, 9'h100)
        end
        setup(5'h11, 8'h05);
        cyc(2);
        `CHK(rsvd, 1'b0)
    endtask : t_rsvd

    task automatic t_gate;
        logic [7:0] c;
        setup(5'h01, 8'hF0);
        wr(1'b1);
        cyc(8);
        `CHK(cnt, 8'h00)
        trig_req = 1'b1;
        wait_cnt(8'h04);
        trig_req = 1'b0;
        cyc(12);
        c = cnt;
        cyc(4);
        `CHK(cnt, c)
        // active-low gate: runs while low, closes on high
        setup(5'h02, 8'hF0);
        wr(1'b1);
        wait_cnt(8'h04);
        trig_req = 1'b1;
        cyc(12);
        c = cnt;
        cyc(4);
        `CHK(cnt, c)
        `CHK(c < 8'h0C, 1'b1)
    endtask : t_gate

    // any-edge reset, then the same edge ignored in debug
    task automatic t_edge;
        setup(5'h03, 8'hF0);
        wr(1'b1);
        wait_cnt(8'h1E);
        trig_req = 1'b1;
        cyc(12);
        `CHK(cnt < 8'h0C, 1'b1)
        wait_cnt(8'h1E);
        trig_req = 1'b0;
        cyc(12);
        `CHK(cnt < 8'h0C, 1'b1)
        dbg = 1'b1;
        wait_cnt(8'h1E);
        trig_req = 1'b1;
        cyc(12);
        `CHK(cnt, 8'h2A)
        dbg = 1'b0;
        // rising-edge reset: a falling edge must leave the count alone
        setup(5'h04, 8'hF0);
        wr(1'b1);
        wait_cnt(8'h0A);
        trig_req = 1'b1;
        cyc(12);
        `CHK(cnt < 8'h0C, 1'b1)
        trig_req = 1'b0;
        cyc(12);
        `CHK(cnt > 8'h0C, 1'b1)
    endtask : t_edge

    task automatic t_oneshot;
        setup(5'h08, 8'h05);
        wr(1'b1);
        wait_cnt(8'h05);
        cyc(1);
        `CHK({ton, pm, cnt}, 10'h100)
        cyc(6);
        `CHK({ton, cnt}, 9'h000)
        // rising start, later rising edge resets, then one-shot stop
        setup(5'h0C, 8'h20);
        wr(1'b1);
        cyc(8);
        trig_req = 1'b1;
        wait_cnt(8'h0A);
        trig_req = 1'b0;
        cyc(8);
        trig_req = 1'b1;
        cyc(8);
        `CHK(cnt < 8'h08, 1'b1)
        wait_cnt(8'h20);
        cyc(1);
        `CHK({ton, cnt}, 9'h000)
    endtask : t_oneshot

    task automatic t_mono;
        setup(5'h11, 8'h05);
        wr(1'b1);
        cyc(10);
        `CHK(cnt, 8'h00)
        trig_req = 1'b1;
        wait_cnt(8'h05);
        cyc(1);
        `CHK({ton, cnt}, 9'h100)
        cyc(6);
        `CHK(cnt, 8'h00)
        // a fresh rising edge restarts the stopped monostable
        trig_req = 1'b0;
        cyc(8);
        trig_req = 1'b1;
        wait_cnt(8'h03);
        `CHK(ton, 1'b1)
    endtask : t_mono

    // re-enable alone must not resume an edge-started count
    task automatic t_restart;
        logic [7:0] c;
        setup(5'h09, 8'hF0);
        wr(1'b1);
        trig_req = 1'b1;
        wait_cnt(8'h0A);
        wr(1'b0);
        cyc(1);
        wr(1'b1);
        c = cnt;
        cyc(10);
        `CHK(cnt, c)
        trig_req = 1'b0;
        cyc(8);
        trig_req = 1'b1;
        wait_cnt(c + 8'h03);
    endtask : t_restart

    task automatic t_level;
        setup(5'h07, 8'hF0);
        wr(1'b1);
        wait_cnt(8'h0A);
        trig_req = 1'b1;
        cyc(12);
        `CHK(cnt, 8'h00)
        setup(5'h16, 8'hF0);
        wr(1'b1);
        cyc(10);
        `CHK(cnt, 8'h00)
        trig_req = 1'b1;
        wait_cnt(8'h05);
        trig_req = 1'b0;
        cyc(12);
        `CHK(cnt, 8'h00)
        // low level holds reset, high level lets it count
        setup(5'h06, 8'hF0);
        wr(1'b1);
        cyc(10);
        `CHK(cnt, 8'h00)
        trig_req = 1'b1;
        wait_cnt(8'h05);
        // low-level start one-shot runs to its period and stops
        setup(5'h17, 8'h08);
        wr(1'b1);
        wait_cnt(8'h08);
        cyc(1);
        `CHK({ton, pm, cnt}, 10'h100)
    endtask : t_level

    // main sequence
    initial begin
        cyc(16);
        sys_rst = 1'b0;
        t_swgate();
        t_lat();
        t_rsvd();
        t_gate();
        t_edge();
        t_oneshot();
        t_mono();
        t_restart();
        t_level();
        end_sim();
    end
endmodule : test_hardware_limit_timer_mode_control

`default_nettype wire
